// ### wwrf_pkg.sv
// constants for the watchdog and reset-cause block
package wwrf_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h60;
  localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 8'h64;
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_IE_BIT = 6;
  localparam int CTRL_SEL3_BIT = 5;
  localparam int CTRL_CE_BIT = 4;
  localparam int CTRL_RSTE_BIT = 3;
  localparam int CTRL_SEL_LO_MSB = 2;
  localparam int CAUSE_JTAG_BIT = 4;
  localparam int CAUSE_WDOG_BIT = 3;
  localparam int CAUSE_BROWN_BIT = 2;
  localparam int CAUSE_PIN_BIT = 1;
  localparam int CAUSE_POWER_BIT = 0;
  localparam int CAUSE_W = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam logic [2:0] CE_CYCLES = 3'h4;
  localparam int CLK_HZ = 20000000;
  localparam int OSC_HZ = 128000;
  localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ;
  localparam int TMO_BASE_DEF = 2048;
  localparam int CNT_W = 21;
  localparam int DIV_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MODE_STOP, MODE_IRQ, MODE_RST, MODE_COMBO} wwrf_mode_t;
endpackage

// ### wwrf_top.sv
// watchdog timer control with reset-cause flags, AXI4-Lite slave
// Summary of operation
// - jtag reset sets bit4; por or zero-write clears
// - watchdog reset sets bit3; por or zero-write clears
// - brownout reset sets bit2; por or zero-write clears
// - pin reset sets bit1; por or zero-write clears
// - power-on sets bit0; only zero-write clears
// - timeout select at bits 5 and 2:0
// - interrupt-mode timeout sets flag bit 7
// - vector execution or one-write clears flag
// - interrupt needs flag, enable and global enable
// - combined mode vector clears enable and flag
// - unserviced second timeout in combined mode resets
// - reset-enable and interrupt-enable select mode
// - programmed fuse forces system reset mode
// - change enable self-clears after four cycles
// - clearing reset-enable or select needs change enable
// - watchdog cause flag forces reset-enable on
// - timeout 2048 ticks doubling per select code up to 9, higher codes saturate
// - counter runs on 128 kHz oscillator ticks
// - programmed fuse locks enables to one, zero
// - reset-mode timeout gives one-cycle reset pulse
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wwrf_top #(
  parameter int OSC_DIV = wwrf_pkg::OSC_DIV_DEF,
  parameter int TMO_BASE = wwrf_pkg::TMO_BASE_DEF
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [wwrf_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [wwrf_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic ALWAYS_ON_FUSE,
  input wire logic CORE_GIE,
  input wire logic VECTOR_ACK,
  input wire logic WDT_RESTART,
  input wire logic JTAG_RESET_EVENT,
  input wire logic PIN_RESET_EVENT,
  input wire logic BROWNOUT_EVENT,
  output logic WDT_IRQ,
  output logic SYS_RESET_REQ
);
  import wwrf_pkg::*;

  localparam logic [CNT_W-1:0] tmo_base = CNT_W'(TMO_BASE);
  localparam logic [DIV_W-1:0] div_last = DIV_W'(OSC_DIV - 1);

  function automatic logic [CNT_W-1:0] tmo_limit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    tmo_limit = tmo_base << s;
  endfunction

  function automatic logic [7:0] ctrl_value(input logic flag, input logic ie, input logic [3:0] sel,
                                            input logic ce, input logic rste);
    ctrl_value = {flag, ie, sel[3], ce, rste, sel[2:0]};
  endfunction

  // bus write holding
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic wr_ctrl;
  logic wr_cause;
  logic wr_mapped;

  // watchdog state
  logic flag;
  logic ie;
  logic rste;
  logic [3:0] sel;
  logic [2:0] ce_cnt;
  logic [CAUSE_W-1:0] cause;
  logic [DIV_W-1:0] div_cnt;
  logic [CNT_W-1:0] wdt_cnt;

  logic fuse_prog;
  logic ce_open;
  logic rste_eff;
  logic ie_eff;
  logic running;
  logic osc_tick;
  logic timeout;
  logic wd_reset_now;
  logic wd_irq_now;
  logic sys_event;
  logic sel_write_ok;
  logic sel_change;
  logic restart;
  logic [3:0] next_sel;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;
  wwrf_mode_t mode;

  assign do_write = aw_have && w_have && !BVALID;
  assign wr_ctrl = do_write && (wr_addr == CTRL_OFFSET) && wr_strb[0];
  assign wr_cause = do_write && (wr_addr == CAUSE_OFFSET) && wr_strb[0];
  assign wr_mapped = (wr_addr == CTRL_OFFSET) || (wr_addr == CAUSE_OFFSET);

  assign fuse_prog = !ALWAYS_ON_FUSE;
  assign ce_open = (ce_cnt != 3'h0);
  assign rste_eff = rste || cause[CAUSE_WDOG_BIT] || fuse_prog;
  assign ie_eff = ie && !fuse_prog;
  assign running = fuse_prog || rste_eff || ie_eff;

  always_comb begin
    if (fuse_prog) begin
      mode = MODE_RST;
    end else begin
      case ({rste_eff, ie_eff})
        2'b01: mode = MODE_IRQ;
        2'b10: mode = MODE_RST;
        2'b11: mode = MODE_COMBO;
        default: mode = MODE_STOP;
      endcase
    end
  end

  // oscillator tick from divider, single clock so the event is already in the bus domain
  assign osc_tick = running && (div_cnt == div_last);
  assign timeout = osc_tick && (wdt_cnt == tmo_limit(sel) - 1'b1);
  assign wd_reset_now = timeout && ((mode == MODE_RST) || ((mode == MODE_COMBO) && flag));
  assign wd_irq_now = timeout && ((mode == MODE_IRQ) || ((mode == MODE_COMBO) && !flag));
  assign sys_event = wd_reset_now || JTAG_RESET_EVENT || PIN_RESET_EVENT || BROWNOUT_EVENT;

  assign next_sel = {wr_data[CTRL_SEL3_BIT], wr_data[CTRL_SEL_LO_MSB:0]};
  assign sel_write_ok = wr_ctrl && ce_open;
  assign sel_change = sel_write_ok && (next_sel != sel);
  assign restart = WDT_RESTART || sel_change || !running || sys_event;

  assign cause_set = {JTAG_RESET_EVENT, wd_reset_now, BROWNOUT_EVENT, PIN_RESET_EVENT, 1'b0};
  assign cause_clr = wr_cause ? ~wr_data[CAUSE_W-1:0] : '0;

  // write address channel
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      AWREADY <= 1'b0;
      aw_have <= 1'b0;
      wr_addr <= '0;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      aw_have <= 1'b1;
      wr_addr <= AWADDR;
    end else begin
      if (do_write) begin
        aw_have <= 1'b0;
      end
      AWREADY <= !aw_have && !BVALID;
    end
  end

  // write data channel
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      WREADY <= 1'b0;
      w_have <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      w_have <= 1'b1;
      wr_data <= WDATA;
      wr_strb <= WSTRB;
    end else begin
      if (do_write) begin
        w_have <= 1'b0;
      end
      WREADY <= !w_have && !BVALID;
    end
  end

  // write response
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= RESP_OKAY;
      if (ARADDR == CTRL_OFFSET) begin
        RDATA <= {24'h0, ctrl_value(flag, ie_eff, sel, ce_open, rste_eff)};
      end else if (ARADDR == CAUSE_OFFSET) begin
        RDATA <= {27'h0, cause};
      end else begin
        RDATA <= '0;
        RRESP <= RESP_SLVERR;
      end
    end else begin
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
      ARREADY <= !RVALID;
    end
  end

  // reset-cause flags, hardware set wins over software clear
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cause <= CAUSE_RESET;
    end else begin
      cause <= cause_set | (cause & ~cause_clr);
    end
  end

  // timeout interrupt flag
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag <= 1'b0;
    end else if (sys_event) begin
      flag <= 1'b0;
    end else if (wd_irq_now) begin
      flag <= 1'b1;
    end else if (VECTOR_ACK || (wr_ctrl && wr_data[CTRL_FLAG_BIT])) begin
      flag <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ie <= 1'b0;
    end else if (sys_event) begin
      ie <= 1'b0;
    end else if (VECTOR_ACK && (mode == MODE_COMBO)) begin
      ie <= 1'b0;
    end else if (wr_ctrl) begin
      ie <= wr_data[CTRL_IE_BIT];
    end
  end

  // system reset enable, cleared by a system event or by a write inside the change window while the watchdog cause flag is clear
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rste <= 1'b0;
    end else if (sys_event) begin
      rste <= 1'b0;
    end else if (wr_ctrl) begin
      if (wr_data[CTRL_RSTE_BIT]) begin
        rste <= 1'b1;
      end else if (ce_open && !cause[CAUSE_WDOG_BIT]) begin
        rste <= 1'b0;
      end
    end
  end

  // timeout select
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel <= SEL_RESET;
    end else if (sys_event) begin
      sel <= SEL_RESET;
    end else if (sel_write_ok) begin
      sel <= next_sel;
    end
  end

  // change enable window
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ce_cnt <= 3'h0;
    end else if (sys_event) begin
      ce_cnt <= 3'h0;
    end else if (wr_ctrl && wr_data[CTRL_CE_BIT]) begin
      ce_cnt <= CE_CYCLES;
    end else if (ce_open) begin
      ce_cnt <= ce_cnt - 3'h1;
    end
  end

  // oscillator divider and watchdog counter
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt <= '0;
      wdt_cnt <= '0;
    end else if (restart) begin
      div_cnt <= '0;
      wdt_cnt <= '0;
    end else if (osc_tick) begin
      div_cnt <= '0;
      wdt_cnt <= timeout ? '0 : wdt_cnt + 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // outputs to core and reset generator
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      WDT_IRQ <= 1'b0;
      SYS_RESET_REQ <= 1'b0;
    end else begin
      WDT_IRQ <= flag && ie_eff && CORE_GIE;
      SYS_RESET_REQ <= wd_reset_now;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  sequence s_open;
    wr_ctrl && wr_data[CTRL_CE_BIT] && !sys_event;
  endsequence
  sequence s_quiet4;
    (!wr_ctrl && !sys_event) [*4];
  endsequence
  property p_ce_holds;
    s_open |=> ce_open [*4];
  endproperty
  a_ce_holds: assert property (p_ce_holds) else $error("change window shorter than four cycles");
  // window counted down to zero one edge after the fourth open cycle
  property p_ce_closes;
    s_open ##1 s_quiet4 |=> !ce_open;
  endproperty
  a_ce_closes: assert property (p_ce_closes) else $error("change window not closed");
  property p_reset_pulse;
    SYS_RESET_REQ |-> cause[CAUSE_WDOG_BIT] ##1 !SYS_RESET_REQ;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not single or cause missing");
  property p_rste_forced;
    cause[CAUSE_WDOG_BIT] |-> rste_eff && ((mode == MODE_RST) || (mode == MODE_COMBO));
  endproperty
  a_rste_forced: assert property (p_rste_forced) else $error("reset enable not forced by cause flag");
  property p_fuse_lock;
    fuse_prog |-> rste_eff && !ie_eff && (mode == MODE_RST);
  endproperty
  a_fuse_lock: assert property (p_fuse_lock) else $error("fuse did not lock reset mode");
  property p_irq;
    ##1 (WDT_IRQ == $past(flag && ie_eff && CORE_GIE));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");
  property p_combo_vector;
    VECTOR_ACK && (mode == MODE_COMBO) && !timeout && !sys_event |=> !ie && !flag && rste_eff;
  endproperty
  a_combo_vector: assert property (p_combo_vector) else $error("combined mode not returned to reset mode");
  property p_sel_locked;
    !ce_open && !sys_event |=> $stable(sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed outside window");
  property p_irq_flag;
    wd_irq_now && !sys_event |=> flag && !SYS_RESET_REQ;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("timeout did not set interrupt flag");
  property p_combo_second;
    timeout && (mode == MODE_COMBO) && flag |=> SYS_RESET_REQ;
  endproperty
  a_combo_second: assert property (p_combo_second) else $error("second timeout gave no reset");
  property p_restart;
    WDT_RESTART |=> (wdt_cnt == '0) && (div_cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not zero counter");
  property p_por_flag;
    cause[CAUSE_POWER_BIT] && !wr_cause |=> cause[CAUSE_POWER_BIT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag lost without write");
  property p_bresp;
    do_write |=> BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule // wwrf_top
`default_nettype wire

// ### wwrf_core_model.sv
// core stand-in: watchdog vector service and restart instructions
`timescale 1ns/1ps
`default_nettype none
module wwrf_core_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic irq,
  input wire logic svc_en,
  input wire logic kick_en,
  output logic vector_ack,
  output logic restart
);
  logic held;
  logic [1:0] tick;
  // one vector per request; the enable is never re-armed here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vector_ack <= 1'b0;
      held <= 1'b0;
    end else begin
      vector_ack <= svc_en && irq && !vector_ack && !held;
      held <= vector_ack || (held && irq);
    end
  end
  // restart every four cycles while kicking, keeps short periods quiet
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 2'h0;
      restart <= 1'b0;
    end else begin
      tick <= tick + 2'h1;
      restart <= kick_en && tick == 2'h0;
    end
  end
endmodule // wwrf_core_model
`default_nettype wire

// ### tb_watchdog_with_reset_flags.sv
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_with_reset_flags;
  import wwrf_pkg::*;
  localparam int OD = 2;
  localparam int TB = 4;
  localparam logic [7:0] CT = CTRL_OFFSET;
  localparam logic [7:0] CS = CAUSE_OFFSET;
  logic clock, arst_n, awvalid, wvalid, bready, arvalid, rready, fuse, gie, jev, pev, bev;
  logic svc_en, kick_en, awready, wready, bvalid, arready, rvalid, irq, sysrst, vack, restart, seen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int bad_count = 0;
  int checks = 0;
  int cnt;
  wwrf_top #(.OSC_DIV(OD), .TMO_BASE(TB)) dut_u (
    .CLOCK(clock), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .ALWAYS_ON_FUSE(fuse), .CORE_GIE(gie),
    .VECTOR_ACK(vack), .WDT_RESTART(restart), .JTAG_RESET_EVENT(jev), .PIN_RESET_EVENT(pev),
    .BROWNOUT_EVENT(bev), .WDT_IRQ(irq), .SYS_RESET_REQ(sysrst));
  wwrf_core_model core_u (.clock(clock), .arst_n(arst_n), .irq(irq), .svc_en(svc_en),
    .kick_en(kick_en), .vector_ack(vack), .restart(restart));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    conclude();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic done = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (bvalid) begin
        r = bresp;
        done = 1'b1;
      end
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end
    if (!done) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    logic done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clock);
      if (rvalid) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    if (!done) hang();
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h0, e});
  endtask
  // waits for the reset request or the interrupt, counting edges
  task automatic wait_out(input logic want_rst, input int lim);
    cnt = 0;
    seen = 1'b0;
    while ((want_rst ? sysrst : irq) !== 1'b1) begin
      @(posedge clock);
      seen = seen | irq;
      cnt++;
      if (cnt > lim) hang();
    end
  endtask
  task automatic ev(input int k);
    jev <= k == 0;
    bev <= k == 1;
    pev <= k == 2;
    @(posedge clock);
    {jev, bev, pev} <= 3'h0;
    cyc(2);
  endtask
  task automatic s_reset();
    rc(CT, 8'h00);
    rc(CS, 8'h01);
    rd(8'h70);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    wr(8'h70, 8'hff);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(CS, 8'hff);
    rc(CS, 8'h01);
  endtask
  task automatic s_events();
    ev(0);
    rc(CS, 8'h11);
    ev(1);
    rc(CS, 8'h15);
    ev(2);
    rc(CS, 8'h17);
    wr(CS, 8'h00);
    rc(CS, 8'h00);
  endtask
  task automatic s_period();
    logic [3:0] s[5] = '{4'h1, 4'h0, 4'h9, 4'hf, 4'h3};
    int c[5];
    gie <= 1'b1;
    foreach (s[i]) begin
      kick_en <= 1'b1;
      // stop and drop the old flag so a stale request cannot end the wait early
      wr(CT, 8'h80);
      wr(CT, 8'h58);
      kick_en <= 1'b0;
      wr(CT, {2'h3, s[i][3], 2'h0, s[i][2:0]});
      wait_out(1'b0, 5000);
      c[i] = cnt;
    end
    foreach (s[i]) chk(32'(c[i] - c[1]), 32'(OD * TB * ((1 << (s[i] > 4'h9 ? 4'h9 : s[i])) - 1)));
  endtask
  task automatic s_irq();
    rc(CT, 8'hc3);
    wr(CT, 8'hc3);
    rc(CT, 8'h43);
    gie <= 1'b0;
    cyc(80);
    chk(32'(irq), 32'h0);
    rc(CT, 8'hc3);
    gie <= 1'b1;
    cyc(3);
    chk(32'(irq), 32'h1);
    wr(CT, 8'h83);
    cyc(80);
    rc(CT, 8'h03);
  endtask
  task automatic s_combo();
    svc_en <= 1'b1;
    wr(CT, 8'h4b);
    wait_out(1'b0, 200);
    kick_en <= 1'b1;
    cyc(4);
    rc(CT, 8'h0b);
    wr(CT, 8'h4b);
    svc_en <= 1'b0;
    kick_en <= 1'b0;
    wait_out(1'b1, 400);
    chk(32'(seen), 32'h1);
    kick_en <= 1'b1;
    @(posedge clock);
    chk(32'(sysrst), 32'h0);
    rc(CS, 8'h08);
    rc(CT, 8'h08);
    wr(CS, 8'h00);
    rc(CT, 8'h00);
  endtask
  task automatic s_protect();
    wr(CT, 8'h08);
    wr(CT, 8'h05);
    rc(CT, 8'h08);
    wr(CT, 8'h18);
    cyc(6);
    rc(CT, 8'h08);
    wr(CT, 8'h01);
    rc(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h05);
    rc(CT, 8'h05);
    kick_en <= 1'b0;
  endtask
  task automatic s_fuse();
    fuse <= 1'b0;
    wr(CT, 8'h40);
    rc(CT, 8'h0d);
    wait_out(1'b1, 600);
    kick_en <= 1'b1;
    rc(CS, 8'h08);
    wr(CS, 8'h00);
    fuse <= 1'b1;
    cyc(2);
    kick_en <= 1'b0;
    rc(CT, 8'h00);
  endtask
  task automatic s_por();
    ev(0);
    arst_n <= 1'b0;
    @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rc(CS, 8'h01);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, jev, pev, bev, svc_en, kick_en, gie} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    fuse = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    s_reset();
    s_events();
    s_period();
    s_irq();
    s_combo();
    s_protect();
    s_fuse();
    s_por();
    conclude();
  end
endmodule // tb_watchdog_with_reset_flags
`default_nettype wire
